/* design/isa_map.svh */
// offsets, encodings and timing counts of the expansion channel link
// included by the package users; definitions only
`ifndef ISA_MAP_SVH
`define ISA_MAP_SVH

// address widths: 20 latched lines plus unlatched 17..23
`define SA_W          20
`define LA_LO         17
`define LA_HI         23
// adapter decode: io block base and 128 kbyte memory window
`define IO_BASE       10'h300
`define MEM_LA_BASE   7'h70
// word index that reads back the user status
`define STATUS_IDX    3'h3
// sbhe_n / sa0 transfer size codes
`define SZ_WORD       2'h0
`define SZ_HIGH       2'h1
`define SZ_LOW        2'h2
// bus clock period and longest ready hold, in ns
`define BUS_CLK_NS    167
`define RDY_MAX_NS    2500
`define RDY_MAX_CYC   (`RDY_MAX_NS / `BUS_CLK_NS)
`define DEV_WAIT_CYC  4'h3
// board side: last core clock count of a bus clock half (count from 0), least wait, reset hold
`define HOST_HALF_DIV 2'h1
`define HOST_MIN_WAIT 4'h6
`define RESET_HOLD    5'h10

`endif

/* design/isa_pkg.sv */
// types shared by both ends of the expansion channel
// assumes isa_map.svh for all figures
package isa_pkg;
  typedef enum logic [1:0] {D_IDLE, D_WAIT, D_SERVE, D_HOLD} dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_CMD, H_WAIT, H_DONE}
    host_state_t;
endpackage : isa_pkg

/* design/isa_channel_if.sv */
// expansion channel wires between the system board and one adapter
// shared lines are resolved here from each end's output enables
`timescale 1ns/1ps
interface isa_channel_if;
  logic        bus_clk;
  logic        reset_drv;
  logic [19:0] sa;
  logic [23:17] la;
  logic        bale;
  logic        aen;
  logic        ior_n;
  logic        iow_n;
  logic        memr_n;
  logic        memw_n;
  logic        sbhe_n;
  logic [15:0] sd_host_out;
  logic        sd_host_oe;
  logic [15:0] sd_dev_out;
  logic        sd_dev_oe;
  logic        rdy_oe;
  logic        mem_cs16_oe;
  logic        io_cs16_oe;
  logic [15:0] sd;
  logic        io_ch_rdy;
  logic        mem_cs16_n;
  logic        io_cs16_n;

  // pulled-up data lines; open-collector lines read high when free
  assign sd = sd_host_oe ? sd_host_out :
              (sd_dev_oe ? sd_dev_out : 16'hFFFF);
  assign io_ch_rdy  = ~rdy_oe;
  assign mem_cs16_n = ~mem_cs16_oe;
  assign io_cs16_n  = ~io_cs16_oe;

  modport board (
    output bus_clk, reset_drv, sa, la, bale, aen, ior_n, iow_n,
           memr_n, memw_n, sbhe_n, sd_host_out, sd_host_oe,
    input  sd, io_ch_rdy, mem_cs16_n, io_cs16_n
  );
  modport adapter (
    input  bus_clk, reset_drv, sa, la, bale, aen, ior_n, iow_n,
           memr_n, memw_n, sbhe_n, sd,
    output sd_dev_out, sd_dev_oe, rdy_oe, mem_cs16_oe, io_cs16_oe
  );
endinterface : isa_channel_if

/* design/isa_adapter_end.sv */
// adapter end: 16-bit io and memory slave on the expansion channel
// runs on the channel bus clock, reset by the channel reset drive
`timescale 1ns/1ps
`include "isa_map.svh"
module isa_adapter_end (
  // channel side
  isa_channel_if.adapter bus,
  // user side, bus clock domain
  input  wire logic [15:0] dev_status,
  output logic             wr_stb,
  output logic [2:0]       wr_idx,
  output logic [15:0]      wr_word
);
  localparam logic [3:0] WAIT_LIM =
    (`DEV_WAIT_CYC > 4'(`RDY_MAX_CYC)) ? 4'(`RDY_MAX_CYC) : `DEV_WAIT_CYC;
  localparam logic [9:0] IO_BASE = `IO_BASE;

  logic [5:0]          s1_ff;
  logic [5:0]          s2_ff;
  logic                bale_s;
  logic                aen_s;
  logic                rd_s;
  logic                wr_s;
  logic                io_cmd_s;
  logic                mem_cmd_s;
  logic [19:0]         sa_lat_ff;
  logic [19:0]         nxt_sa_lat;
  logic                la_hit_ff;
  logic                nxt_la_hit;
  logic                valid_ff;
  logic                nxt_valid;
  logic                io_hit_ff;
  logic                nxt_io_hit;
  logic                mcs_ff;
  logic                nxt_mcs;
  logic                ics_ff;
  logic                nxt_ics;
  isa_pkg::dev_state_t st_ff;
  isa_pkg::dev_state_t nxt_st;
  logic [3:0]          cnt_ff;
  logic [3:0]          nxt_cnt;
  logic                rdy_ff;
  logic                nxt_rdy;
  logic                cyc_rd_ff;
  logic                nxt_cyc_rd;
  logic                cyc_io_ff;
  logic                nxt_cyc_io;
  logic [2:0]          cyc_idx_ff;
  logic [2:0]          nxt_cyc_idx;
  logic [1:0]          cyc_sz_ff;
  logic [1:0]          nxt_cyc_sz;
  logic [15:0]         dout_ff;
  logic [15:0]         nxt_dout;
  logic                doe_ff;
  logic                nxt_doe;
  logic [15:0]         mem_ff [8];
  logic [15:0]         nxt_mem [8];
  logic                wst_ff;
  logic                nxt_wst;
  logic [2:0]          widx_ff;
  logic [2:0]          nxt_widx;
  logic [15:0]         wword_ff;
  logic [15:0]         nxt_wword;
  logic                io_req;
  logic                mem_req;
  logic [15:0]         merged;

  // strobes and latch strobe arrive from another clock
  // bus clock samples; the ready hold is counted in its cycles, capped by a count taken from its rate
  always_ff @(posedge bus.bus_clk or posedge bus.reset_drv) begin
    if (bus.reset_drv) begin
      s1_ff <= 6'h00;
      s2_ff <= 6'h00;
    end else begin
      s1_ff <= {bus.bale, bus.aen, ~bus.ior_n, ~bus.iow_n,
                ~bus.memr_n, ~bus.memw_n};
      s2_ff <= s1_ff;
    end
  end

  assign bale_s    = s2_ff[5];
  assign aen_s     = s2_ff[4];
  assign rd_s      = s2_ff[3] | s2_ff[1];
  assign wr_s      = s2_ff[2] | s2_ff[0];
  assign io_cmd_s  = s2_ff[3] | s2_ff[2];
  assign mem_cmd_s = s2_ff[1] | s2_ff[0];

  // io decode ignores the latch strobe, blocked under dma
  assign io_req  = io_cmd_s & io_hit_ff & ~aen_s;
  assign mem_req = mem_cmd_s & valid_ff & la_hit_ff;

  // address capture and decode
  always_comb begin
    nxt_sa_lat = sa_lat_ff;
    nxt_la_hit = la_hit_ff;
    nxt_valid  = valid_ff;
    // transparent while high, frozen from the falling edge on
    if (bale_s) begin
      nxt_sa_lat = bus.sa;
      nxt_la_hit = (bus.la == `MEM_LA_BASE);
      nxt_valid  = 1'b1;
    end else if (st_ff == isa_pkg::D_HOLD && !rd_s && !wr_s) begin
      nxt_valid = 1'b0;
    end
    nxt_io_hit = (bus.sa[9:3] == IO_BASE[9:3]);
    // select lines live from decode, not from the command
    nxt_mcs = bale_s ? (bus.la == `MEM_LA_BASE) : la_hit_ff;
    nxt_ics = io_hit_ff & ~aen_s;
  end

  always_ff @(posedge bus.bus_clk or posedge bus.reset_drv) begin
    if (bus.reset_drv) begin
      sa_lat_ff <= 20'h00000;
      la_hit_ff <= 1'b0;
      valid_ff  <= 1'b0;
      io_hit_ff <= 1'b0;
      mcs_ff    <= 1'b0;
      ics_ff    <= 1'b0;
    end else begin
      sa_lat_ff <= nxt_sa_lat;
      la_hit_ff <= nxt_la_hit;
      valid_ff  <= nxt_valid;
      io_hit_ff <= nxt_io_hit;
      mcs_ff    <= nxt_mcs;
      ics_ff    <= nxt_ics;
    end
  end

  // write data merged on the lanes named by sbhe_n and sa0
  always_comb begin
    merged = mem_ff[cyc_idx_ff];
    if (cyc_sz_ff != `SZ_HIGH) begin
      merged[7:0] = bus.sd[7:0];
    end
    if (cyc_sz_ff != `SZ_LOW) begin
      merged[15:8] = bus.sd[15:8];
    end
  end

  // cycle sequencer
  always_comb begin
    nxt_st      = st_ff;
    nxt_cnt     = cnt_ff;
    nxt_rdy     = rdy_ff;
    nxt_cyc_rd  = cyc_rd_ff;
    nxt_cyc_io  = cyc_io_ff;
    nxt_cyc_idx = cyc_idx_ff;
    nxt_cyc_sz  = cyc_sz_ff;
    nxt_dout    = dout_ff;
    nxt_doe     = doe_ff;
    nxt_wst     = 1'b0;
    nxt_widx    = widx_ff;
    nxt_wword   = wword_ff;
    for (int i = 0; i < 8; i++) begin
      nxt_mem[i] = mem_ff[i];
    end
    case (st_ff)
      isa_pkg::D_IDLE: begin
        nxt_doe = 1'b0;
        if (io_req || mem_req) begin
          nxt_st      = isa_pkg::D_WAIT;
          nxt_rdy     = 1'b1;
          nxt_cnt     = 4'h0;
          nxt_cyc_rd  = rd_s;
          nxt_cyc_io  = io_req;
          nxt_cyc_idx = io_req ? {1'b0, bus.sa[2:1]} : bus.sa[3:1];
          nxt_cyc_sz  = {bus.sbhe_n, bus.sa[0]};
        end
      end
      isa_pkg::D_WAIT: begin
        nxt_cnt = cnt_ff + 4'h1;
        // longest hold capped at the channel limit
        if (cnt_ff >= WAIT_LIM - 4'h1) begin
          nxt_st  = isa_pkg::D_SERVE;
          nxt_rdy = 1'b0;
          // data leaves with ready so both cross the board's sync together
          nxt_doe = cyc_rd_ff & rd_s;
          if (cyc_io_ff && cyc_idx_ff == `STATUS_IDX) begin
            nxt_dout = dev_status;
          end else begin
            nxt_dout = mem_ff[cyc_idx_ff];
          end
        end
      end
      isa_pkg::D_SERVE: begin
        nxt_st = isa_pkg::D_HOLD;
        if (cyc_rd_ff) begin
          nxt_doe = rd_s;
        end else begin
          nxt_mem[cyc_idx_ff] = merged;
          nxt_wst   = 1'b1;
          nxt_widx  = cyc_idx_ff;
          nxt_wword = merged;
        end
      end
      isa_pkg::D_HOLD: begin
        nxt_doe = cyc_rd_ff & rd_s;
        if (!rd_s && !wr_s) begin
          nxt_st = isa_pkg::D_IDLE;
        end
      end
      default: nxt_st = isa_pkg::D_IDLE;
    endcase
  end

  always_ff @(posedge bus.bus_clk or posedge bus.reset_drv) begin
    if (bus.reset_drv) begin
      st_ff      <= isa_pkg::D_IDLE;
      cnt_ff     <= 4'h0;
      rdy_ff     <= 1'b0;
      cyc_rd_ff  <= 1'b0;
      cyc_io_ff  <= 1'b0;
      cyc_idx_ff <= 3'h0;
      cyc_sz_ff  <= 2'h3;
      dout_ff    <= 16'h0000;
      doe_ff     <= 1'b0;
      wst_ff     <= 1'b0;
      widx_ff    <= 3'h0;
      wword_ff   <= 16'h0000;
      for (int i = 0; i < 8; i++) begin
        mem_ff[i] <= 16'h0000;
      end
    end else begin
      st_ff      <= nxt_st;
      cnt_ff     <= nxt_cnt;
      rdy_ff     <= nxt_rdy;
      cyc_rd_ff  <= nxt_cyc_rd;
      cyc_io_ff  <= nxt_cyc_io;
      cyc_idx_ff <= nxt_cyc_idx;
      cyc_sz_ff  <= nxt_cyc_sz;
      dout_ff    <= nxt_dout;
      doe_ff     <= nxt_doe;
      wst_ff     <= nxt_wst;
      widx_ff    <= nxt_widx;
      wword_ff   <= nxt_wword;
      for (int i = 0; i < 8; i++) begin
        mem_ff[i] <= nxt_mem[i];
      end
    end
  end

  assign bus.sd_dev_out  = dout_ff;
  assign bus.sd_dev_oe   = doe_ff;
  assign bus.rdy_oe      = rdy_ff;
  assign bus.mem_cs16_oe = mcs_ff;
  assign bus.io_cs16_oe  = ics_ff;
  assign wr_stb          = wst_ff;
  assign wr_idx          = widx_ff;
  assign wr_word         = wword_ff;
endmodule : isa_adapter_end

/* design/isa_board_end.sv */
// system board end: makes the bus clock and reset drive, runs cycles
// user requests arrive on core_clk; channel inputs are synchronised
`timescale 1ns/1ps
`include "isa_map.svh"
module isa_board_end (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // channel side
  isa_channel_if.board     bus,
  // request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic        req_mem,
  input  wire logic        req_dma,
  input  wire logic        req_word,
  input  wire logic [23:0] req_addr,
  input  wire logic [15:0] req_wdata,
  // answer
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata
);
  isa_pkg::host_state_t st_ff, nxt_st;
  logic [1:0]  div_ff, nxt_div;
  logic        clk_ff, nxt_clk;
  logic        tick;
  logic [4:0]  rcnt_ff, nxt_rcnt;
  logic        rdrv_ff, nxt_rdrv;
  logic [18:0] s1_ff, s2_ff;
  logic        rdy_s;
  logic        cs16_s;
  logic [3:0]  wcnt_ff, nxt_wcnt;
  logic        wr_ff, nxt_wr, mem_ff, nxt_mem, dma_ff, nxt_dma;
  logic        word_ff, nxt_word, half_ff, nxt_half;
  logic [23:0] addr_ff, nxt_addr;
  logic [15:0] wdat_ff, nxt_wdat, rdat_ff, nxt_rdat;
  logic        bale_ff, nxt_bale, aen_ff, nxt_aen;
  logic        cmd_ff, nxt_cmd, sbhe_ff, nxt_sbhe;
  logic [15:0] dout_ff, nxt_dout;
  logic        doe_ff, nxt_doe, rdy_ff, nxt_rdyo, rsp_ff, nxt_rsp;

  // outputs move on the bus clock fall, settled at the adapter's rise
  assign tick   = (div_ff == `HOST_HALF_DIV) & clk_ff;
  assign rdy_s  = s2_ff[18];
  assign cs16_s = mem_ff ? s2_ff[17] : s2_ff[16];

  always_comb begin
    nxt_div  = (div_ff == `HOST_HALF_DIV) ? 2'h0 : div_ff + 2'h1;
    nxt_clk  = (div_ff == `HOST_HALF_DIV) ? ~clk_ff : clk_ff;
    nxt_rcnt = rdrv_ff ? rcnt_ff + 5'h01 : rcnt_ff;
    nxt_rdrv = rdrv_ff & (rcnt_ff != `RESET_HOLD);
    nxt_st = st_ff;   nxt_wcnt = wcnt_ff; nxt_wr = wr_ff;
    nxt_mem = mem_ff; nxt_dma = dma_ff;   nxt_word = word_ff;
    nxt_half = half_ff; nxt_addr = addr_ff; nxt_wdat = wdat_ff;
    nxt_rdat = rdat_ff; nxt_bale = bale_ff; nxt_aen = aen_ff;
    nxt_cmd = cmd_ff; nxt_sbhe = sbhe_ff; nxt_dout = dout_ff;
    nxt_doe = doe_ff; nxt_rdyo = rdy_ff; nxt_rsp = 1'b0;
    case (st_ff)
      isa_pkg::H_IDLE: begin
        nxt_rdyo = ~rdrv_ff;
        if (req_valid && rdy_ff) begin
          nxt_rdyo = 1'b0;
          nxt_wr = req_write; nxt_mem = req_mem; nxt_dma = req_dma;
          nxt_word = req_word; nxt_addr = req_addr;
          nxt_wdat = req_wdata; nxt_half = 1'b0;
          nxt_st = isa_pkg::H_ADDR;
        end
      end
      isa_pkg::H_ADDR: if (tick) begin
        nxt_bale = 1'b1;
        nxt_aen  = dma_ff;
        nxt_sbhe = ~(word_ff | addr_ff[0]);
        nxt_st   = isa_pkg::H_CMD;
      end
      isa_pkg::H_CMD: if (tick) begin
        nxt_bale = dma_ff;
        nxt_cmd  = 1'b1;
        nxt_doe  = wr_ff;
        // second half of a split word rides the low lanes
        nxt_dout = half_ff ? {wdat_ff[15:8], wdat_ff[15:8]}
                           : wdat_ff;
        nxt_wcnt = `HOST_MIN_WAIT;
        nxt_st   = isa_pkg::H_WAIT;
      end
      isa_pkg::H_WAIT: if (tick) begin
        if (wcnt_ff != 4'h0) begin
          nxt_wcnt = wcnt_ff - 4'h1;
        end else if (rdy_s) begin
          nxt_cmd = 1'b0; nxt_bale = 1'b0; nxt_doe = 1'b0;
          if (half_ff) begin
            nxt_rdat[15:8] = s2_ff[7:0];
          end else begin
            nxt_rdat = s2_ff[15:0];
          end
          if (word_ff && !cs16_s && !half_ff) begin
            nxt_half = 1'b1;
            nxt_word = 1'b0;
            nxt_addr = addr_ff | 24'h000001;
            nxt_st   = isa_pkg::H_ADDR;
          end else begin
            nxt_st = isa_pkg::H_DONE;
          end
        end
      end
      isa_pkg::H_DONE: begin
        nxt_aen = 1'b0;
        nxt_rsp = 1'b1;
        nxt_st  = isa_pkg::H_IDLE;
      end
      default: nxt_st = isa_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= isa_pkg::H_IDLE; div_ff <= 2'h0; clk_ff <= 1'b0;
      rcnt_ff <= 5'h00; rdrv_ff <= 1'b1; s1_ff <= 19'h00000;
      s2_ff <= 19'h00000; wcnt_ff <= 4'h0; wr_ff <= 1'b0;
      mem_ff <= 1'b0; dma_ff <= 1'b0; word_ff <= 1'b0;
      half_ff <= 1'b0; addr_ff <= 24'h000000; wdat_ff <= 16'h0000;
      rdat_ff <= 16'h0000; bale_ff <= 1'b0; aen_ff <= 1'b0;
      cmd_ff <= 1'b0; sbhe_ff <= 1'b1; dout_ff <= 16'h0000;
      doe_ff <= 1'b0; rdy_ff <= 1'b0; rsp_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st; div_ff <= nxt_div; clk_ff <= nxt_clk;
      rcnt_ff <= nxt_rcnt; rdrv_ff <= nxt_rdrv;
      // channel lines come from the adapter's clock
      s1_ff <= {bus.io_ch_rdy, ~bus.mem_cs16_n, ~bus.io_cs16_n, bus.sd};
      s2_ff <= s1_ff;
      wcnt_ff <= nxt_wcnt; wr_ff <= nxt_wr; mem_ff <= nxt_mem;
      dma_ff <= nxt_dma; word_ff <= nxt_word; half_ff <= nxt_half;
      addr_ff <= nxt_addr; wdat_ff <= nxt_wdat; rdat_ff <= nxt_rdat;
      bale_ff <= nxt_bale; aen_ff <= nxt_aen; cmd_ff <= nxt_cmd;
      sbhe_ff <= nxt_sbhe; dout_ff <= nxt_dout; doe_ff <= nxt_doe;
      rdy_ff <= nxt_rdyo; rsp_ff <= nxt_rsp;
    end
  end

  assign bus.bus_clk     = clk_ff;
  assign bus.reset_drv   = rdrv_ff;
  assign bus.sa          = addr_ff[19:0];
  assign bus.la          = addr_ff[23:17];
  assign bus.bale        = bale_ff;
  assign bus.aen         = aen_ff;
  assign bus.sbhe_n      = sbhe_ff;
  assign bus.ior_n       = ~(cmd_ff & ~mem_ff & ~wr_ff);
  assign bus.iow_n       = ~(cmd_ff & ~mem_ff & wr_ff);
  assign bus.memr_n      = ~(cmd_ff & mem_ff & ~wr_ff);
  assign bus.memw_n      = ~(cmd_ff & mem_ff & wr_ff);
  assign bus.sd_host_out = dout_ff;
  assign bus.sd_host_oe  = doe_ff;
  assign req_ready       = rdy_ff;
  assign rsp_valid       = rsp_ff;
  assign rsp_rdata       = rdat_ff;
endmodule : isa_board_end

/* sim/isa_channel_monitor.sv */
// concurrent checks on the expansion channel wires
// assumes bus_clk and reset_drv are made by the board end
`timescale 1ns/1ps
`include "isa_map.svh"
module isa_channel_monitor (
  // channel clock and reset
  input wire logic         bus_clk,
  input wire logic         reset_drv,
  // address and commands
  input wire logic [19:0]  sa,
  input wire logic [23:17] la,
  input wire logic         bale,
  input wire logic         aen,
  input wire logic         ior_n,
  input wire logic         iow_n,
  input wire logic         memr_n,
  input wire logic         memw_n,
  input wire logic         sbhe_n,
  // adapter enables
  input wire logic         sd_dev_oe,
  input wire logic         rdy_oe,
  input wire logic         mem_cs16_oe,
  input wire logic         io_cs16_oe
);
  localparam int RDY_MAX = `RDY_MAX_CYC;
  localparam logic [9:0] IO_BASE = `IO_BASE;
  localparam logic [6:0] MEM_LA = `MEM_LA_BASE;
  logic [4:0] rdy_cnt_ff;
  logic [4:0] nxt_rdy_cnt;
  logic       io_hit;
  logic       io_strb;
  logic       mem_strb;
  logic       rd_act;
  assign io_hit   = (sa[9:3] == IO_BASE[9:3]);
  assign io_strb  = !(ior_n && iow_n);
  assign mem_strb = !(memr_n && memw_n);
  assign rd_act   = !ior_n || !memr_n;
  // length of the current not-ready stretch
  always_comb begin
    nxt_rdy_cnt = rdy_oe ? rdy_cnt_ff + 5'h01 : 5'h00;
  end
  always_ff @(posedge bus_clk or posedge reset_drv) begin
    if (reset_drv) rdy_cnt_ff <= 5'h00;
    else rdy_cnt_ff <= nxt_rdy_cnt;
  end
  default clocking cb @(posedge bus_clk); endclocking
  default disable iff (reset_drv);
  a_ready_bound: assert property (rdy_cnt_ff <= RDY_MAX)
    else $error("ready held low too long");
  a_ready_on_access: assert property ($rose(io_strb) && io_hit && !aen
    |-> ##[1:4] rdy_oe) else $error("no ready pull on own io access");
  a_ready_length: assert property ($rose(rdy_oe)
    |-> rdy_oe[*3] ##1 !rdy_oe) else $error("ready wait length wrong");
  a_mem_ready: assert property ($rose(mem_strb) && la == MEM_LA
    |-> ##[1:4] rdy_oe) else $error("no ready pull on own memory access");
  a_mem_select: assert property ($rose(mem_cs16_oe)
    |-> $past(bale, 3) && $past(la == MEM_LA))
    else $error("memory select without upper decode");
  a_io_select: assert property (io_cs16_oe
    |-> $past(io_hit, 2) && !$past(aen, 3))
    else $error("io select without decode");
  a_dma_silent: assert property (aen && $rose(io_strb)
    |-> ##2 (!rdy_oe && !io_cs16_oe)[*5]) else $error("answer during dma");
  a_read_drive: assert property (sd_dev_oe |-> rd_act || $past(rd_act)
    || $past(rd_act, 2) || $past(rd_act, 3))
    else $error("data driven outside a read");
  a_bale_dma: assert property (aen && (io_strb || mem_strb) |-> bale)
    else $error("latch strobe low in dma cycle");
  a_size_code: assert property (io_strb || mem_strb |-> !(sbhe_n && sa[0]))
    else $error("reserved size code used");
endmodule : isa_channel_monitor

/* sim/tb_isa_io_channel_adapter_port.sv */
// bench joining board end and adapter end across the channel
// assumes the board end makes bus_clk from core_clk
`timescale 1ns/1ps
module tb_isa_io_channel_adapter_port;
  logic        core_clk, reset_n, req_valid, req_ready, req_write;
  logic        req_mem, req_dma, req_word, rsp_valid, wr_stb;
  logic [23:0] req_addr;
  logic [15:0] req_wdata, rsp_rdata, dev_status, wr_word, a, b;
  logic [15:0] img [4];
  logic [2:0]  wr_idx;
  logic [31:0] rng;
  logic [16:0] rn, rsp_q [$];
  logic [18:0] wn, wr_q [$];
  int          n_errors, n_tests;
  isa_channel_if isa_channel_if_inst ();
  isa_board_end isa_board_end_inst (.core_clk(core_clk), .reset_n(reset_n),
    .bus(isa_channel_if_inst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_mem(req_mem), .req_dma(req_dma),
    .req_word(req_word), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  isa_adapter_end isa_adapter_end_inst (.bus(isa_channel_if_inst),
    .dev_status(dev_status), .wr_stb(wr_stb), .wr_idx(wr_idx),
    .wr_word(wr_word));
  isa_channel_monitor isa_channel_monitor_inst (
    .bus_clk(isa_channel_if_inst.bus_clk),
    .reset_drv(isa_channel_if_inst.reset_drv),
    .sa(isa_channel_if_inst.sa), .la(isa_channel_if_inst.la),
    .bale(isa_channel_if_inst.bale), .aen(isa_channel_if_inst.aen),
    .ior_n(isa_channel_if_inst.ior_n), .iow_n(isa_channel_if_inst.iow_n),
    .memr_n(isa_channel_if_inst.memr_n), .memw_n(isa_channel_if_inst.memw_n),
    .sbhe_n(isa_channel_if_inst.sbhe_n),
    .sd_dev_oe(isa_channel_if_inst.sd_dev_oe),
    .rdy_oe(isa_channel_if_inst.rdy_oe),
    .mem_cs16_oe(isa_channel_if_inst.mem_cs16_oe),
    .io_cs16_oe(isa_channel_if_inst.io_cs16_oe));

  always #20 core_clk = ~core_clk;

  function automatic logic [15:0] rnd16();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[15:0];
  endfunction : rnd16

  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // every wait is bounded; a hang ends the run as a failure
  task automatic wait_ready();
    int k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 3000);
    if (k >= 3000) begin
      n_errors++;
      end_of_test();
    end
  endtask : wait_ready

  task automatic op(input logic w, m, d, wd, input logic [23:0] ad,
                    input logic [15:0] dat, input logic rc,
                    input logic [15:0] rexp);
    wait_ready();
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_mem   <= m;
    req_dma   <= d;
    req_word  <= wd;
    req_addr  <= ad;
    req_wdata <= dat;
    rsp_q.push_back({rc, rexp});
    wait_ready();
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask : op

  always @(negedge core_clk) if (rsp_valid === 1'b1) begin
    if (rsp_q.size() == 0) check(19'h1, 19'h0);
    else begin
      rn = rsp_q.pop_front();
      if (rn[16]) check({3'h0, rsp_rdata}, {3'h0, rn[15:0]});
    end
  end

  always @(negedge isa_channel_if_inst.bus_clk) if (wr_stb === 1'b1) begin
    if (wr_q.size() == 0) check(19'h1, 19'h0);
    else begin
      wn = wr_q.pop_front();
      check({wr_idx, wr_word}, wn);
    end
  end

  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_mem = 1'b0;
    req_dma = 1'b0;
    req_word = 1'b0;
    req_addr = 24'h000000;
    req_wdata = 16'h0000;
    dev_status = 16'h0000;
    rng = 32'h0000F959;
    n_errors = 0;
    n_tests = 0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      img[i] = rnd16();
      wr_q.push_back({i[2:0], img[i]});
      op(1, 0, 0, 1, 24'h000300 + 24'(2 * i), img[i], 0, 16'h0000);
    end
    b = rnd16();
    @(posedge core_clk);
    dev_status <= b;
    for (int i = 0; i < 4; i++)
      op(0, 0, 0, 1, 24'h000300 + 24'(2 * i), 16'h0000, 1,
         (i == 3) ? b : img[i]);
    $display("done: io words");
    a = rnd16();
    wr_q.push_back({3'h1, a[15:8], img[1][7:0]});
    op(1, 0, 0, 0, 24'h000303, a, 0, 16'h0000);
    img[1][15:8] = a[15:8];
    wr_q.push_back({3'h1, img[1][15:8], a[7:0]});
    op(1, 0, 0, 0, 24'h000302, a, 0, 16'h0000);
    img[1][7:0] = a[7:0];
    op(0, 0, 0, 1, 24'h000302, 16'h0000, 1, img[1]);
    $display("done: byte lanes");
    // upper io address bits are ignored by the decode
    img[2] = rnd16();
    wr_q.push_back({3'h2, img[2]});
    op(1, 0, 0, 1, 24'h00F304, img[2], 0, 16'h0000);
    op(1, 0, 1, 1, 24'h000304, rnd16(), 0, 16'h0000);
    op(1, 0, 0, 1, 24'h000310, rnd16(), 0, 16'h0000);
    op(0, 0, 0, 1, 24'h000310, 16'h0000, 1, 16'hFFFF);
    op(0, 0, 0, 1, 24'h000304, 16'h0000, 1, img[2]);
    $display("done: io decode and dma");
    a = rnd16();
    wr_q.push_back({3'h5, a});
    op(1, 1, 0, 1, 24'hE1000A, a, 0, 16'h0000);
    op(1, 1, 0, 1, 24'h0E000A, rnd16(), 0, 16'h0000);
    op(1, 1, 0, 1, 24'h60000A, rnd16(), 0, 16'h0000);
    op(0, 1, 0, 1, 24'hE0000A, 16'h0000, 1, a);
    $display("done: memory window");
    wait_ready();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    op(0, 0, 0, 1, 24'h000302, 16'h0000, 1, 16'h0000);
    wait_ready();
    repeat (40) @(posedge core_clk);
    check(19'(rsp_q.size() + wr_q.size()), 19'h0);
    $display("done: reset");
    end_of_test();
  end
endmodule : tb_isa_io_channel_adapter_port
